// ---- sss_pkg.sv ----
// Behaviour
// - Modulator select 00 feeds constant zero
// - Modulator select 01 feeds constant one
// - Modulator select 10 feeds encoder envelope, reset
// - Modulator select 11 feeds auxiliary input pin
// - Aux out 000 low, 001 high, 11x reserved
// - Aux out 010 drives encoder envelope
// - Aux out 011 drives unencoded transmit data
// - Aux out 100 drives regenerated card signal
// - Aux out 101 drives subcarrier demodulator output
// - Aux select works only with override clear
// - Digital split side: aux 2, decoder 2
// - Decoder select: zero, analog, subcarrier, Manchester
`default_nettype none
package sss_pkg;
  // Register byte offsets
  localparam logic [7:0] SSS_TRANSMIT_CONTROL = 8'h00;
  localparam logic [7:0] SSS_RECEIVE_CONTROL_SECOND = 8'h04;
  localparam logic [7:0] SSS_AUX_OUT_SEL = 8'h08;
  localparam logic [7:0] SSS_DIGITAL_TEST = 8'h0c;
  localparam logic [7:0] SSS_RATE_CONTROL = 8'h10;
  localparam logic [7:0] SSS_STATUS = 8'h14;
  // Field positions
  localparam int SSS_MOD_SEL_LSB = 0;
  localparam int SSS_DEC_SEL_LSB = 0;
  localparam int SSS_AUX_SEL_LSB = 0;
  localparam int SSS_OVR_BIT = 0;
  localparam int SSS_TST_SEL_LSB = 4;
  localparam int SSS_TX_RATE_LSB = 0;
  localparam int SSS_RX_RATE_LSB = 4;
  // Reset values
  localparam logic [1:0] SSS_MOD_SEL_RST = 2'h2;
  localparam logic [1:0] SSS_DEC_SEL_RST = 2'h1;
  localparam logic [2:0] SSS_AUX_SEL_RST = 3'h0;
  localparam logic SSS_OVR_RST = 1'b0;
  localparam logic [2:0] SSS_TST_SEL_RST = 3'h0;
  localparam logic [1:0] SSS_RATE_RST = 2'h0;
  // Modulator source codes
  typedef enum logic [1:0] {
    SSS_MOD_ZERO = 2'b00,
    SSS_MOD_ONE = 2'b01,
    SSS_MOD_ENCODER = 2'b10,
    SSS_MOD_AUX_IN = 2'b11
  } sss_mod_sel_t;
  // Decoder source codes
  typedef enum logic [1:0] {
    SSS_DEC_ZERO = 2'b00,
    SSS_DEC_ANALOG = 2'b01,
    SSS_DEC_AUX_SUBC = 2'b10,
    SSS_DEC_AUX_MANCH = 2'b11
  } sss_dec_sel_t;
  // Auxiliary output codes
  typedef enum logic [2:0] {
    SSS_AUX_LOW = 3'b000,
    SSS_AUX_HIGH = 3'b001,
    SSS_AUX_ENVELOPE = 3'b010,
    SSS_AUX_TX_DATA = 3'b011,
    SSS_AUX_RX_REGEN = 3'b100,
    SSS_AUX_SUBC_DEMOD = 3'b101,
    SSS_AUX_RSVD6 = 3'b110,
    SSS_AUX_RSVD7 = 3'b111
  } sss_aux_sel_t;
  // Bit rate codes
  typedef enum logic [1:0] {
    SSS_RATE_106 = 2'b00,
    SSS_RATE_212 = 2'b01,
    SSS_RATE_424 = 2'b10,
    SSS_RATE_RSVD = 2'b11
  } sss_rate_t;
  localparam int SSS_SAMPLE_W = 2;
  localparam int SSS_TEST_W = 8;
endpackage
`default_nettype wire

// ---- sss_stream_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Valid/ready stream between switch and sample buffer
interface sss_stream_if #(
  parameter int WIDTH = 2
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- sss_buffer.sv ----
`timescale 1ns/100ps
`default_nettype none
// Two-entry buffer, all outputs from flops
module sss_buffer #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic reset_n,
  sss_stream_if.snk in_s,
  sss_stream_if.src out_s
);
  logic [WIDTH-1:0] ent_q [DEPTH];
  logic [1:0] cnt_q;
  logic rdy_q;
  logic vld_q;
  logic push;
  logic pop;
  logic [1:0] cnt_d;

  // Structure is a fixed two-deep shift buffer
  if (DEPTH != 2 || WIDTH < 1) begin
    $error("sss_buffer serves DEPTH 2 and WIDTH >= 1 only");
  end

  // Transfer handshakes
  assign push = in_s.valid && rdy_q;
  assign pop = out_s.ready && (cnt_q != 2'd0);
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

  // Occupancy and ready
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_q <= 2'd0;
      rdy_q <= 1'b0;
      vld_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rdy_q <= (cnt_d != 2'd2);
      vld_q <= (cnt_d != 2'd0); // Head valid straight from a flop
    end
  end

  // Head in entry 0, shifts on pop
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ent_q[0] <= '0;
      ent_q[1] <= '0;
    end else begin
      if (pop) begin
        ent_q[0] <= (cnt_q == 2'd2) ? ent_q[1] : in_s.data;
      end else if (push && cnt_q == 2'd0) begin
        ent_q[0] <= in_s.data;
      end
      if (push && ((cnt_q == 2'd1 && !pop) || (cnt_q == 2'd2))) begin
        ent_q[1] <= in_s.data;
      end
    end
  end

  assign in_s.ready = rdy_q;
  assign out_s.valid = vld_q;
  assign out_s.data = ent_q[0];
endmodule
`default_nettype wire

// ---- sss_switch.sv ----
`timescale 1ns/100ps
`default_nettype none
// Serial signal switch with APB register slave
module sss_switch (
  input wire logic mclk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic aux_serial_in,
  output logic aux_serial_out,
  output logic antenna_drive_1,
  output logic antenna_drive_2,
  // Analog receiver comparator, asynchronous
  input wire logic analog_rx_in,
  // Digital core signals, same clock
  input wire logic encoder_envelope,
  input wire logic tx_serial_data,
  input wire logic rx_regenerated,
  input wire logic subcarrier_demod,
  input wire logic [sss_pkg::SSS_TEST_W-1:0] test_signals,
  // Decoder sample strobe and stream
  input wire logic dec_sample_strobe,
  output logic dec_sample_ready,
  output logic dec_valid,
  output logic [sss_pkg::SSS_SAMPLE_W-1:0] dec_data,
  input wire logic dec_ready,
  // Rate settings toward coder and decoder
  output logic [1:0] tx_rate,
  output logic [1:0] rx_rate
);
  import sss_pkg::*;

  sss_mod_sel_t mod_sel_q;
  sss_dec_sel_t dec_sel_q;
  sss_aux_sel_t aux_sel_q;
  logic ovr_q;
  logic [2:0] tst_sel_q;
  sss_rate_t tx_rate_q;
  sss_rate_t rx_rate_q;
  logic aux_meta_q;
  logic aux_sync_q;
  logic ana_meta_q;
  logic ana_sync_q;
  logic mod_q;
  logic aux_out_q;
  logic dec_bit;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_val;
  logic rd_hit;
  logic setup;
  logic wr_en;

  sss_stream_if #(.WIDTH(SSS_SAMPLE_W)) in_s ();
  sss_stream_if #(.WIDTH(SSS_SAMPLE_W)) out_s ();

  // Two-stage synchronisers for pins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      aux_meta_q <= 1'b0;
      aux_sync_q <= 1'b0;
      ana_meta_q <= 1'b0;
      ana_sync_q <= 1'b0;
    end else begin
      aux_meta_q <= aux_serial_in;
      aux_sync_q <= aux_meta_q;
      ana_meta_q <= analog_rx_in;
      ana_sync_q <= ana_meta_q;
    end
  end

  // APB phase decode
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;

  // Read mux and address hit
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      SSS_TRANSMIT_CONTROL: begin
        rd_val[SSS_MOD_SEL_LSB +: 2] = mod_sel_q;
      end
      SSS_RECEIVE_CONTROL_SECOND: begin
        rd_val[SSS_DEC_SEL_LSB +: 2] = dec_sel_q;
      end
      SSS_AUX_OUT_SEL: begin
        rd_val[SSS_AUX_SEL_LSB +: 3] = aux_sel_q;
      end
      SSS_DIGITAL_TEST: begin
        rd_val[SSS_OVR_BIT] = ovr_q;
        rd_val[SSS_TST_SEL_LSB +: 3] = tst_sel_q;
      end
      SSS_RATE_CONTROL: begin
        rd_val[SSS_TX_RATE_LSB +: 2] = tx_rate_q;
        rd_val[SSS_RX_RATE_LSB +: 2] = rx_rate_q;
      end
      SSS_STATUS: begin
        rd_val[0] = mod_q;
        rd_val[1] = aux_out_q;
        rd_val[2] = aux_sync_q;
        rd_val[3] = ana_sync_q;
        rd_val[4] = out_s.valid;
        rd_val[5] = in_s.ready;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // APB answer: one access cycle, data latched at setup
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      pready_q <= 1'b1;
      pslverr_q <= !rd_hit || (pwrite && paddr == SSS_STATUS);
      prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
  end

  // Routing selects, written at the access edge
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mod_sel_q <= sss_mod_sel_t'(SSS_MOD_SEL_RST);
      dec_sel_q <= sss_dec_sel_t'(SSS_DEC_SEL_RST);
      aux_sel_q <= sss_aux_sel_t'(SSS_AUX_SEL_RST);
    end else if (wr_en) begin
      case (paddr)
        SSS_TRANSMIT_CONTROL: begin
          mod_sel_q <= sss_mod_sel_t'(pwdata[SSS_MOD_SEL_LSB +: 2]);
        end
        SSS_RECEIVE_CONTROL_SECOND: begin
          dec_sel_q <= sss_dec_sel_t'(pwdata[SSS_DEC_SEL_LSB +: 2]);
        end
        SSS_AUX_OUT_SEL: begin
          aux_sel_q <= sss_aux_sel_t'(pwdata[SSS_AUX_SEL_LSB +: 3]);
        end
        default: begin
        end
      endcase
    end
  end

  // Test override and rate fields
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ovr_q <= SSS_OVR_RST;
      tst_sel_q <= SSS_TST_SEL_RST;
      tx_rate_q <= sss_rate_t'(SSS_RATE_RST);
      rx_rate_q <= sss_rate_t'(SSS_RATE_RST);
    end else if (wr_en && paddr == SSS_DIGITAL_TEST) begin
      ovr_q <= pwdata[SSS_OVR_BIT];
      tst_sel_q <= pwdata[SSS_TST_SEL_LSB +: 3];
    end else if (wr_en && paddr == SSS_RATE_CONTROL) begin
      tx_rate_q <= sss_rate_t'(pwdata[SSS_TX_RATE_LSB +: 2]);
      rx_rate_q <= sss_rate_t'(pwdata[SSS_RX_RATE_LSB +: 2]);
    end
  end

  // Modulator source mux, drives both antenna pins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mod_q <= 1'b0;
    end else begin
      case (mod_sel_q)
        SSS_MOD_ZERO: mod_q <= 1'b0;
        SSS_MOD_ONE: mod_q <= 1'b1;
        SSS_MOD_ENCODER: mod_q <= encoder_envelope;
        SSS_MOD_AUX_IN: mod_q <= aux_sync_q;
        default: mod_q <= 1'b0;
      endcase
    end
  end

  // Auxiliary output mux; test override wins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      aux_out_q <= 1'b0;
    end else if (ovr_q) begin
      aux_out_q <= test_signals[tst_sel_q];
    end else begin
      case (aux_sel_q)
        SSS_AUX_LOW: aux_out_q <= 1'b0;
        SSS_AUX_HIGH: aux_out_q <= 1'b1;
        SSS_AUX_ENVELOPE: aux_out_q <= encoder_envelope;
        SSS_AUX_TX_DATA: aux_out_q <= tx_serial_data;
        SSS_AUX_RX_REGEN: aux_out_q <= rx_regenerated;
        SSS_AUX_SUBC_DEMOD: aux_out_q <= subcarrier_demod;
        default: aux_out_q <= 1'b0;
      endcase
    end
  end

  // Decoder source mux
  always_comb begin
    case (dec_sel_q)
      SSS_DEC_ZERO: dec_bit = 1'b0;
      SSS_DEC_ANALOG: dec_bit = ana_sync_q;
      SSS_DEC_AUX_SUBC: dec_bit = aux_sync_q;
      SSS_DEC_AUX_MANCH: dec_bit = aux_sync_q;
      default: dec_bit = 1'b0;
    endcase
  end

  // Decoder samples: bit plus subcarrier-expected flag
  assign in_s.valid = dec_sample_strobe;
  assign in_s.data = {dec_sel_q == SSS_DEC_AUX_SUBC, dec_bit};
  assign out_s.ready = dec_ready;

  sss_buffer #(
    .WIDTH(SSS_SAMPLE_W),
    .DEPTH(2)
  ) u_buffer (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_s(in_s),
    .out_s(out_s)
  );

  // Outputs
  assign antenna_drive_1 = mod_q;
  assign antenna_drive_2 = mod_q;
  assign aux_serial_out = aux_out_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign dec_sample_ready = in_s.ready;
  assign dec_valid = out_s.valid;
  assign dec_data = out_s.data;
  assign tx_rate = tx_rate_q;
  assign rx_rate = rx_rate_q;

  // Checks on routing
  property p_mod_zero;
    @(posedge mclk) disable iff (!reset_n)
      (mod_sel_q == SSS_MOD_ZERO) |=> !antenna_drive_1 && !antenna_drive_2;
  endproperty
  a_mod_zero: assert property (p_mod_zero) else $error("Carrier on with select 00");

  property p_mod_one;
    @(posedge mclk) disable iff (!reset_n)
      (mod_sel_q == SSS_MOD_ONE) |=> antenna_drive_1 && antenna_drive_2;
  endproperty
  a_mod_one: assert property (p_mod_one) else $error("Carrier off with select 01");

  property p_mod_enc;
    @(posedge mclk) disable iff (!reset_n)
      (mod_sel_q == SSS_MOD_ENCODER) |=> antenna_drive_1 == $past(encoder_envelope);
  endproperty
  a_mod_enc: assert property (p_mod_enc) else $error("Modulator not envelope");

  property p_mod_aux;
    @(posedge mclk) disable iff (!reset_n)
      (mod_sel_q == SSS_MOD_AUX_IN) |=> antenna_drive_1 == $past(aux_sync_q);
  endproperty
  a_mod_aux: assert property (p_mod_aux) else $error("Modulator not aux input");

  property p_aux_const;
    @(posedge mclk) disable iff (!reset_n)
      (!ovr_q && aux_sel_q inside {SSS_AUX_LOW, SSS_AUX_RSVD6, SSS_AUX_RSVD7})
        |=> !aux_serial_out;
  endproperty
  a_aux_const: assert property (p_aux_const) else $error("Aux out not low");

  property p_aux_high;
    @(posedge mclk) disable iff (!reset_n)
      (!ovr_q && aux_sel_q == SSS_AUX_HIGH) |=> aux_serial_out;
  endproperty
  a_aux_high: assert property (p_aux_high) else $error("Aux out not high");

  property p_aux_write;
    @(posedge mclk) disable iff (!reset_n)
      (psel && penable && pready && pwrite && !pslverr && paddr == SSS_AUX_OUT_SEL
        && pwdata[2:0] == 3'b001 && !ovr_q) |-> ##2 aux_serial_out;
  endproperty
  a_aux_write: assert property (p_aux_write) else $error("Aux write not applied");

  property p_aux_env;
    @(posedge mclk) disable iff (!reset_n)
      (!ovr_q && aux_sel_q == SSS_AUX_ENVELOPE) |=> aux_serial_out == $past(encoder_envelope);
  endproperty
  a_aux_env: assert property (p_aux_env) else $error("Aux out not envelope");

  property p_aux_txd;
    @(posedge mclk) disable iff (!reset_n)
      (!ovr_q && aux_sel_q == SSS_AUX_TX_DATA) |=> aux_serial_out == $past(tx_serial_data);
  endproperty
  a_aux_txd: assert property (p_aux_txd) else $error("Aux out not tx data");

  property p_aux_regen;
    @(posedge mclk) disable iff (!reset_n)
      (!ovr_q && aux_sel_q == SSS_AUX_RX_REGEN) |=> aux_serial_out == $past(rx_regenerated);
  endproperty
  a_aux_regen: assert property (p_aux_regen) else $error("Aux out not regen");

  property p_aux_demod;
    @(posedge mclk) disable iff (!reset_n)
      (!ovr_q && aux_sel_q == SSS_AUX_SUBC_DEMOD)
        |=> aux_serial_out == $past(subcarrier_demod);
  endproperty
  a_aux_demod: assert property (p_aux_demod) else $error("Aux out not demod");

  property p_ovr;
    @(posedge mclk) disable iff (!reset_n)
      ovr_q |=> aux_serial_out == $past(test_signals[tst_sel_q]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("Override not honoured");

  property p_dec_src;
    @(posedge mclk) disable iff (!reset_n)
      (dec_sample_strobe && dec_sample_ready && !dec_valid)
        |=> dec_valid && dec_data == $past({dec_sel_q == SSS_DEC_AUX_SUBC, dec_bit});
  endproperty
  a_dec_src: assert property (p_dec_src) else $error("Decoder sample wrong");

  property p_write_applies;
    @(posedge mclk) disable iff (!reset_n)
      (psel && penable && pready && pwrite && !pslverr && paddr == SSS_TRANSMIT_CONTROL
        && pwdata[1:0] == 2'b00) |-> ##2 !antenna_drive_1;
  endproperty
  a_write_applies: assert property (p_write_applies) else $error("Write not applied");
endmodule
`default_nettype wire

// ---- sss_far_reader.sv ----
`timescale 1ns/100ps
`default_nettype none
// Far reader driving the auxiliary input pin
module sss_far_reader (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic active,
  input wire logic level,
  output logic aux_serial_in
);
  logic flip_q;
  // Idle pattern, changes every cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      flip_q <= 1'b0;
    end else begin
      flip_q <= ~flip_q;
    end
  end
  // One RF path at a time, 106 kBd Miller level
  assign aux_serial_in = active ? level : flip_q;
endmodule
`default_nettype wire

// ---- serial_signal_switch_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module serial_signal_switch_tb;
  import sss_pkg::*;
  typedef struct packed {
    logic [1:0] m;
    logic [2:0] a;
    logic [1:0] d;
    logic [5:0] in;
    logic [3:0] e;
  } sss_row_t;
  localparam sss_row_t ROWS [10] = '{
    '{2'h0, 3'h0, 2'h0, 6'h3f, 4'h0}, '{2'h1, 3'h1, 2'h1, 6'h00, 4'hc},
    '{2'h2, 3'h2, 2'h1, 6'h21, 4'hd}, '{2'h2, 3'h3, 2'h2, 6'h12, 4'h7},
    '{2'h0, 3'h2, 2'h2, 6'h20, 4'h6}, '{2'h3, 3'h4, 2'h3, 6'h0a, 4'hd},
    '{2'h3, 3'h5, 2'h3, 6'h24, 4'h4}, '{2'h1, 3'h6, 2'h0, 6'h3f, 4'h8},
    '{2'h1, 3'h7, 2'h0, 6'h3f, 4'h8}, '{2'h0, 3'h4, 2'h1, 6'h11, 4'h1}};
  localparam logic [7:0] RA [5] = '{SSS_TRANSMIT_CONTROL, SSS_RECEIVE_CONTROL_SECOND,
    SSS_AUX_OUT_SEL, SSS_DIGITAL_TEST, SSS_RATE_CONTROL};
  localparam logic [31:0] RV [5] = '{32'h2, 32'h1, 32'h0, 32'h0, 32'h0};
  logic mclk;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic aux_serial_in;
  logic aux_serial_out;
  logic antenna_drive_1;
  logic antenna_drive_2;
  logic analog_rx_in = 1'b0;
  logic encoder_envelope = 1'b0;
  logic tx_serial_data = 1'b0;
  logic rx_regenerated = 1'b0;
  logic subcarrier_demod = 1'b0;
  logic [7:0] test_signals = 8'h00;
  logic dec_sample_strobe = 1'b0;
  logic dec_sample_ready;
  logic dec_valid;
  logic [1:0] dec_data;
  logic dec_ready = 1'b0;
  logic [1:0] tx_rate;
  logic [1:0] rx_rate;
  logic pin_on = 1'b0;
  logic pin_level = 1'b0;
  logic [31:0] rdv;
  logic erv;
  int checks = 0;
  int failures = 0;
  int cycles = 0;
  sss_switch sss_switch_inst (.mclk(mclk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .aux_serial_in(aux_serial_in),
    .aux_serial_out(aux_serial_out), .antenna_drive_1(antenna_drive_1),
    .antenna_drive_2(antenna_drive_2), .analog_rx_in(analog_rx_in),
    .encoder_envelope(encoder_envelope), .tx_serial_data(tx_serial_data),
    .rx_regenerated(rx_regenerated), .subcarrier_demod(subcarrier_demod),
    .test_signals(test_signals), .dec_sample_strobe(dec_sample_strobe),
    .dec_sample_ready(dec_sample_ready), .dec_valid(dec_valid), .dec_data(dec_data),
    .dec_ready(dec_ready), .tx_rate(tx_rate), .rx_rate(rx_rate));
  sss_far_reader sss_far_reader_inst (.mclk(mclk), .reset_n(reset_n), .active(pin_on),
    .level(pin_level), .aux_serial_in(aux_serial_in));
  // Clock at 25 MHz
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic push;
    @(posedge mclk);
    dec_sample_strobe <= 1'b1;
    @(posedge mclk);
    dec_sample_strobe <= 1'b0;
  endtask
  // Wait for head, compare, take it
  task automatic pop(input logic [1:0] exp);
    @(posedge mclk);
    while (dec_valid !== 1'b1) @(posedge mclk);
    `CHK(dec_data, exp)
    dec_ready <= 1'b1;
    @(posedge mclk);
    dec_ready <= 1'b0;
  endtask
  // Reset, quiet outputs, reset values
  task automatic do_reset;
    reset_n <= 1'b0;
    settle(2);
    `CHK({antenna_drive_1, aux_serial_out, pready, dec_sample_ready}, 4'h0)
    @(posedge mclk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, RA[i], 32'h0);
      `CHK(rdv, RV[i])
    end
  endtask
  initial begin
    do_reset();
    encoder_envelope <= 1'b1;
    settle(2);
    `CHK(antenna_drive_1, 1'b1)
    // Table of routing cases
    foreach (ROWS[i]) begin
      apb(1'b1, SSS_TRANSMIT_CONTROL, {30'h0, ROWS[i].m});
      apb(1'b1, SSS_AUX_OUT_SEL, {29'h0, ROWS[i].a});
      apb(1'b1, SSS_RECEIVE_CONTROL_SECOND, {30'h0, ROWS[i].d});
      pin_on <= 1'b1;
      {encoder_envelope, tx_serial_data, rx_regenerated, subcarrier_demod, pin_level,
        analog_rx_in} <= ROWS[i].in;
      settle(5);
      `CHK(antenna_drive_1, ROWS[i].e[3])
      `CHK(antenna_drive_2, ROWS[i].e[3])
      `CHK(aux_serial_out, ROWS[i].e[2])
      push();
      pop(ROWS[i].e[1:0]);
    end
    // Override takes the aux pin away
    test_signals <= 8'h00;
    apb(1'b1, SSS_AUX_OUT_SEL, 32'h1);
    apb(1'b1, SSS_DIGITAL_TEST, 32'h31);
    settle(2);
    `CHK(aux_serial_out, 1'b0)
    @(posedge mclk);
    test_signals <= 8'h08;
    settle(2);
    `CHK(aux_serial_out, 1'b1)
    @(posedge mclk);
    test_signals <= 8'h00;
    apb(1'b1, SSS_DIGITAL_TEST, 32'h0);
    settle(2);
    `CHK(aux_serial_out, 1'b1)
    // Select change lands one edge after the write
    @(posedge mclk);
    {encoder_envelope, analog_rx_in} <= 2'h3;
    apb(1'b1, SSS_TRANSMIT_CONTROL, 32'h2);
    apb(1'b1, SSS_TRANSMIT_CONTROL, 32'h0);
    #1;
    `CHK(antenna_drive_1, 1'b1)
    settle(1);
    `CHK(antenna_drive_1, 1'b0)
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, SSS_RATE_CONTROL, 32'(i * 17));
      settle(1);
      `CHK({tx_rate, rx_rate}, 4'(i * 5))
    end
    // Fill the buffer with the consumer stalled, then drain
    apb(1'b1, SSS_RECEIVE_CONTROL_SECOND, 32'h1);
    settle(4);
    push();
    apb(1'b1, SSS_RECEIVE_CONTROL_SECOND, 32'h0);
    push();
    settle(2);
    `CHK(dec_sample_ready, 1'b0)
    apb(1'b1, SSS_RECEIVE_CONTROL_SECOND, 32'h3);
    push();
    pop(2'h1);
    pop(2'h0);
    settle(3);
    `CHK(dec_valid, 1'b0)
    // Unmapped and read-only places refuse
    apb(1'b0, 8'h18, 32'h0);
    `CHK({erv, rdv}, 33'h100000000)
    apb(1'b1, SSS_STATUS, 32'hffffffff);
    `CHK(erv, 1'b1)
    do_reset();
    give_verdict();
  end
endmodule
`default_nettype wire
